// ===== bench/ee_bus_master.sv
// behavioural two-wire bus master driving scl and pulling sda low
// assumes a pull-up on sda, wire level fed back on i_sda
`timescale 1ns/1ps
module ee_bus_master (
    output logic o_scl,
    output logic o_sda_low,
    output logic o_start,
    output logic o_stop,
    input wire logic i_sda
);
    localparam realtime HALF = 62.5; // half of the 125 ns link period
    // idle bus: scl high, sda released, stop seen last
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
        o_start = 1'b0;
        o_stop = 1'b1;
    end
    // free clocks with sda released, used around reset only
    task automatic pulses(input int n);
        repeat (n) begin
            #HALF o_scl = 1'b0;
            #HALF o_scl = 1'b1;
        end
    endtask : pulses
    // one bit: change data while scl low, sample while high
    task automatic bit_slot(input logic low, output logic seen);
        o_sda_low = low;
        #HALF o_scl = 1'b1;
        #(HALF / 2) seen = i_sda;
        o_start = 1'b0;
        #(HALF / 2) o_scl = 1'b0;
    endtask : bit_slot
    // start or repeated start; a restart costs one extra rise
    task automatic start_cond();
        if (!o_scl) begin
            o_sda_low = 1'b0;
            #HALF o_scl = 1'b1;
        end
        #HALF o_sda_low = 1'b1;
        o_stop = 1'b0;
        o_start = 1'b1;
        #HALF o_scl = 1'b0;
    endtask : start_cond
    // stop, then scl stands high
    task automatic stop_cond();
        o_sda_low = 1'b1;
        #HALF o_scl = 1'b1;
        #HALF o_sda_low = 1'b0;
        o_stop = 1'b1;
        #HALF;
    endtask : stop_cond
    // msb first, line released in the ack slot
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_slot(!b[i], s);
        bit_slot(1'b0, s);
        ack = !s;
    endtask : send_byte
    // read a byte, ack unless it is the last
    task automatic recv_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'b0, s);
            b[i] = s;
        end
        bit_slot(!last, s);
    endtask : recv_byte
endmodule : ee_bus_master

// ===== bench/eeprom_monitor.sv
// port-level assertions for the two-wire eeprom engine
// assumes binding from the bench top, scl standing high between frames
`timescale 1ns/1ps
module eeprom_monitor #(
    parameter eeprom_pkg::variant_t VARIANT = eeprom_pkg::VAR_4K,
    parameter int unsigned WRITE_CYCLES = 200
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_bus_start,
    input wire logic i_bus_stop,
    input wire eeprom_pkg::cs_pins_t i_chip_select_pins,
    input wire logic o_sda_out,
    input wire logic o_sda_oe,
    input wire logic o_busy
);
    import eeprom_pkg::*;
    logic [3:0] cnt; // bits seen in this byte, 9 after the ack slot
    logic [7:0] sh; // last eight sampled bits
    logic first; // first byte after a start
    logic wr; // acked write frame
    logic rd; // acked read frame, until the master nacks
    logic [31:0] blen; // cycles busy has stood
    // address compare per variant; page bits never take part
    function automatic logic hit(input logic [7:0] a);
        if (a[7:4] != 4'hA) return 1'b0;
        if (VARIANT == VAR_4K) return a[3:2] == {i_chip_select_pins.chip_select_pin_high,
            i_chip_select_pins.chip_select_pin_mid};
        if (VARIANT == VAR_8K) return a[3] == i_chip_select_pins.chip_select_pin_high;
        return a[3:1] == 3'h0;
    endfunction : hit
    // bit framing on scl rises
    always_ff @(posedge i_scl) begin
        sh <= {sh[6:0], i_sda};
        cnt <= (i_bus_start || cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
    end
    // frame kind, learnt from the device's own answer
    always_ff @(posedge i_scl) begin
        if (!i_reset_n || i_bus_start) begin
            first <= i_reset_n;
            wr <= 1'b0;
            rd <= 1'b0;
        end else if (cnt == 4'h8 && first) begin
            first <= 1'b0;
            wr <= o_sda_oe && !sh[0];
            rd <= o_sda_oe && sh[0];
        end else if (cnt == 4'h8 && rd && i_sda) begin
            rd <= 1'b0;
        end
    end
    // length of the busy span
    always_ff @(posedge i_mclk) begin
        blen <= (!i_reset_n || !o_busy) ? 32'h0 : blen + 32'h1;
    end
    a_sda_out_low: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        o_sda_out == 1'b0) else $error("sda data output not low");
    a_busy_from_stop: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        $rose(o_busy) |-> $past(i_bus_stop, 2)) else $error("busy without a stop");
    a_busy_length: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        $fell(o_busy) |-> blen == WRITE_CYCLES) else $error("write cycle length wrong");
    a_busy_silent: assert property (@(posedge i_scl) disable iff (!i_reset_n)
        o_busy && $past(o_busy) && $past(o_busy, 2) |-> !o_sda_oe) else $error("answer while busy");
    a_addr_ack: assert property (@(posedge i_scl) disable iff (!i_reset_n)
        first && cnt == 4'h8 && o_busy == $past(o_busy, 3) |-> o_sda_oe == (hit(sh) && !o_busy))
        else $error("device address answer wrong");
    a_wdata_ack: assert property (@(posedge i_scl) disable iff (!i_reset_n)
        wr && !first && cnt == 4'h8 |-> o_sda_oe) else $error("write byte not acked");
    a_rack_release: assert property (@(posedge i_scl) disable iff (!i_reset_n)
        rd && !first && cnt == 4'h8 |-> !o_sda_oe) else $error("sda held in master ack slot");
    a_idle_quiet: assert property (@(posedge i_scl) disable iff (!i_reset_n)
        !(first || wr || rd) |-> !o_sda_oe) else $error("sda pulled outside a frame");
    c_ack_seen: cover property (@(posedge i_scl) first && cnt == 4'h8 && o_sda_oe);
    c_read_nack: cover property (@(posedge i_scl) rd && cnt == 4'h8 && i_sda);
    c_busy_start: cover property (@(posedge i_mclk) $rose(o_busy));
endmodule : eeprom_monitor

// ===== bench/tb.sv
// self-checking bench for the eeprom engine, 4K and module variants on one bus, short write cycle
// assumes the bus master model and the port monitor beside it
`timescale 1ns/1ps
module tb;
    import eeprom_pkg::*;
    logic mclk = 1'b0; // 10 MHz system clock
    logic reset_n = 1'b0; // held low from time zero
    cs_pins_t pins = 3'b101; // high and low straps set; low is ignored in 4K
    logic scl, sda_low, bus_start, bus_stop, sda_out, sda_oe, busy;
    logic sda_out_m, sda_oe_m, busy_m; // second device, module variant
    // wired-and bus: pulled up unless someone pulls
    wire sda = !((sda_oe && !sda_out) || (sda_oe_m && !sda_out_m) || sda_low);
    int num_errors = 0;
    int comparisons = 0;
    logic ack;
    logic [7:0] rd_b;
    always #50 mclk = !mclk;
    ee_bus_master ee_bus_master_inst (.o_scl(scl), .o_sda_low(sda_low), .o_start(bus_start),
        .o_stop(bus_stop), .i_sda(sda));
    eeprom_engine #(.VARIANT(VAR_4K), .WRITE_CYCLES(200)) eeprom_engine_inst (.i_mclk(mclk),
        .i_reset_n(reset_n), .i_scl(scl), .i_sda(sda), .i_bus_start(bus_start), .i_bus_stop(bus_stop),
        .i_chip_select_pins(pins), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_busy(busy));
    // module variant answers only 1010_000x, so it shares the bus with the 4K part
    eeprom_engine #(.VARIANT(VAR_MODULE), .WRITE_CYCLES(200)) eeprom_engine_module_inst (.i_mclk(mclk),
        .i_reset_n(reset_n), .i_scl(scl), .i_sda(sda), .i_bus_start(bus_start), .i_bus_stop(bus_stop),
        .i_chip_select_pins(pins), .o_sda_out(sda_out_m), .o_sda_oe(sda_oe_m), .o_busy(busy_m));
    task automatic check_bit(input string what, input logic exp, input logic seen);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %b seen %b", what, exp, seen);
        end
    endtask : check_bit
    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] seen);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check_byte
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic send(input logic [7:0] b, input logic exp_ack);
        ee_bus_master_inst.send_byte(b, ack);
        check_bit("ack", exp_ack, ack);
    endtask : send
    task automatic fetch(input logic last, input logic [7:0] exp);
        ee_bus_master_inst.recv_byte(last, rd_b);
        check_byte("read data", exp, rd_b);
    endtask : fetch
    // link domain needs scl rises inside reset and after it
    task automatic do_reset();
        @(negedge mclk) reset_n = 1'b0;
        fork
            repeat (10) @(negedge mclk);
            ee_bus_master_inst.pulses(8);
        join
        reset_n = 1'b1;
        ee_bus_master_inst.pulses(4);
    endtask : do_reset
    task automatic begin_at(input logic [7:0] dev, input logic [7:0] word);
        ee_bus_master_inst.start_cond();
        send(dev, 1'b1);
        send(word, 1'b1);
    endtask : begin_at
    // stop, poll while busy, wait bounded, poll again
    task automatic end_write(input logic [7:0] dev);
        int n;
        logic mod;
        mod = (dev == 8'hA0);
        ee_bus_master_inst.stop_cond();
        repeat (6) @(negedge mclk);
        check_bit("busy", 1'b1, mod ? busy_m : busy);
        ee_bus_master_inst.start_cond();
        send(dev, 1'b0);
        ee_bus_master_inst.stop_cond();
        n = 0;
        while ((mod ? busy_m : busy) !== 1'b0 && n < 400) begin
            @(negedge mclk);
            n++;
        end
        check_bit("busy", 1'b0, mod ? busy_m : busy);
        ee_bus_master_inst.start_cond();
        send(dev, 1'b1);
        ee_bus_master_inst.stop_cond();
    endtask : end_write
    // main sequence
    initial begin
        do_reset();
        ee_bus_master_inst.start_cond();
        send(8'hA4, 1'b0);
        ee_bus_master_inst.start_cond();
        send(8'hB8, 1'b0);
        ee_bus_master_inst.stop_cond();
        begin_at(8'hAA, 8'hFF);
        send(8'h5A, 1'b1);
        end_write(8'hA8);
        begin_at(8'hA8, 8'h00);
        send(8'hC3, 1'b1);
        end_write(8'hA8);
        begin_at(8'hAA, 8'hFF);
        ee_bus_master_inst.start_cond();
        send(8'hA9, 1'b1);
        fetch(1'b1, 8'h5A);
        ee_bus_master_inst.start_cond();
        send(8'hA9, 1'b1);
        fetch(1'b1, 8'hC3);
        ee_bus_master_inst.stop_cond();
        begin_at(8'hA8, 8'h1E);
        for (int k = 0; k < 17; k++) send(8'h40 + k[7:0], 1'b1);
        end_write(8'hA8);
        begin_at(8'hA8, 8'h10);
        ee_bus_master_inst.start_cond();
        send(8'hA9, 1'b1);
        for (int j = 0; j < 16; j++) fetch(j == 15, (j == 14) ? 8'h50 : 8'h40 + 8'((j + 2) % 16));
        ee_bus_master_inst.stop_cond();
        // module variant: low three address bits must be zero
        ee_bus_master_inst.start_cond();
        send(8'hA2, 1'b0);
        begin_at(8'hA0, 8'hFF);
        send(8'h3C, 1'b1);
        end_write(8'hA0);
        begin_at(8'hA0, 8'hFF);
        ee_bus_master_inst.start_cond();
        send(8'hA1, 1'b1);
        fetch(1'b1, 8'h3C);
        ee_bus_master_inst.stop_cond();
        do_reset();
        ee_bus_master_inst.start_cond();
        send(8'hA9, 1'b1);
        fetch(1'b1, 8'hC3);
        ee_bus_master_inst.stop_cond();
        tally_and_finish();
    end
    // hang guard, well beyond the expected 170 us
    initial begin
        #2000000;
        num_errors++;
        $display("BAD watchdog expected done seen timeout");
        tally_and_finish();
    end
endmodule : tb
bind eeprom_engine eeprom_monitor #(.VARIANT(VARIANT), .WRITE_CYCLES(WRITE_CYCLES)) eeprom_monitor_inst (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_scl(i_scl), .i_sda(i_sda), .i_bus_start(i_bus_start),
    .i_bus_stop(i_bus_stop), .i_chip_select_pins(i_chip_select_pins), .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe), .o_busy(o_busy));

// ===== shared/eeprom_pkg.sv
// types shared by the eeprom protocol engine files
// assumes eeprom_regs.svh is on the include path
package eeprom_pkg;
    `include "eeprom_regs.svh"

    // part variant: how device address bits 3..1 are used
    typedef enum logic [1:0] {
        VAR_4K = 2'h0,
        VAR_8K = 2'h1,
        VAR_MODULE = 2'h2
    } variant_t;

    // protocol engine states, one-hot
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_DEV = 5'h02,
        S_WADDR = 5'h04,
        S_WDATA = 5'h08,
        S_RDATA = 5'h10
    } eng_state_t;

    // hard-wired chip select straps
    typedef struct packed {
        logic chip_select_pin_high;
        logic chip_select_pin_mid;
        logic chip_select_pin_low;
    } cs_pins_t;
endpackage : eeprom_pkg

// ===== shared/eeprom_regs.svh
// constants of the two-wire eeprom protocol engine
// assumes inclusion by bare name from package and modules
`ifndef EEPROM_REGS_SVH
`define EEPROM_REGS_SVH

// fixed one-zero pattern in the top nibble of the device address word
`define EE_DEV_CODE 4'hA
// bits per byte and position of the acknowledge slot
`define EE_BYTE_BITS 4'h8
// page of 16 bytes: low word-address bits that increment during writes
`define EE_PAGE_BITS 4
// internal write cycle, longest time in ms, and the system clock in kHz
`define EE_WRITE_TIME_MS 5
`define EE_MCLK_KHZ 10000
// longest time as a whole number of clock cycles, ms times kHz
`define EE_WRITE_CYCLES (`EE_WRITE_TIME_MS * `EE_MCLK_KHZ)
// counter reset value
`define EE_ADDR_RESET 10'h000

`endif

// ===== src/ee_sync2.sv
// two flip-flop synchroniser for a group of levels
// assumes the inputs are levels that stay stable for several destination clocks
`timescale 1ns/1ps
module ee_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    // first stage, read only by the second stage
    logic [WIDTH-1:0] meta;

    // plain double flop; no reset so the reset input itself may pass through
    always_ff @(posedge i_clk) begin
        meta <= i_async;
        o_sync <= meta;
    end
endmodule : ee_sync2

// ===== src/ee_write_timer.sv
// self-timed write cycle on the system clock
// assumes i_stop_flag comes from an external stop detector, i_armed from the link domain
`timescale 1ns/1ps
`include "eeprom_regs.svh"
module ee_write_timer #(
    parameter int unsigned WRITE_CYCLES = `EE_WRITE_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_stop_flag,
    input wire logic i_armed,
    output logic o_busy
);
    import eeprom_pkg::*;

    logic stop_s; // synchronised stop level
    logic armed_s; // synchronised pending-write level
    logic stop_d; // previous stop level for edge detect
    logic launched; // cycle already run for this pending write
    logic [31:0] cnt; // cycles left in the write cycle

    ee_sync2 #(.WIDTH(2)) u_sync (
        .i_clk(i_mclk),
        .i_async({i_stop_flag, i_armed}),
        .o_sync({stop_s, armed_s})
    );

    // stop edge with a pending write launches the timed cycle
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            stop_d <= 1'b1; // idle bus shows a stop; avoids a false edge after reset
            launched <= 1'b0;
            o_busy <= 1'b0;
            cnt <= 32'h0000_0000;
        end else begin
            stop_d <= stop_s;
            if (o_busy) begin
                // count down the longest write time
                if (cnt == 32'h0000_0001) begin
                    o_busy <= 1'b0;
                end
                cnt <= cnt - 32'h0000_0001;
            end else if (stop_s && !stop_d && armed_s && !launched) begin
                o_busy <= 1'b1;
                launched <= 1'b1;
                cnt <= 32'(WRITE_CYCLES);
            end
            // handshake: link side drops armed once it has seen busy
            if (!armed_s && !o_busy) begin
                launched <= 1'b0;
            end
        end
    end
endmodule : ee_write_timer

// ===== src/eeprom_engine.sv
// two-wire serial eeprom protocol engine, device side
// assumes an external start/stop detector, an open-drain pad outside,
// scl as the link clock and a 10 MHz system clock for the write timer
`timescale 1ns/1ps
`include "eeprom_regs.svh"

module eeprom_engine #(
    parameter eeprom_pkg::variant_t VARIANT = eeprom_pkg::VAR_4K,
    parameter int unsigned WRITE_CYCLES = `EE_WRITE_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_bus_start,
    input wire logic i_bus_stop,
    input wire eeprom_pkg::cs_pins_t i_chip_select_pins,
    output logic o_sda_out,
    output logic o_sda_oe,
    output logic o_busy
);
    import eeprom_pkg::*;

    // address width per variant
    function automatic int addr_width(input variant_t v);
        if (v == VAR_4K) begin
            return 9;
        end else if (v == VAR_8K) begin
            return 10;
        end
        return 8;
    endfunction : addr_width

    localparam int AW = addr_width(VARIANT);
    localparam int DEPTH = 1 << AW;
    localparam int PB = `EE_PAGE_BITS;

    // device address compare against the straps, or against zero for the module variant
    function automatic logic dev_match(input logic [7:0] b, input cs_pins_t p);
        logic ok;
        ok = (b[7:4] == `EE_DEV_CODE);
        if (VARIANT == VAR_4K) begin
            ok = ok && (b[3] == p.chip_select_pin_high) && (b[2] == p.chip_select_pin_mid);
        end else if (VARIANT == VAR_8K) begin
            ok = ok && (b[3] == p.chip_select_pin_high);
        end else begin
            ok = ok && (b[3:1] == 3'h0);
        end
        return ok;
    endfunction : dev_match

    // page bits carried in the device address word
    function automatic logic [1:0] dev_page(input logic [7:0] b);
        if (VARIANT == VAR_4K) begin
            return {1'b0, b[1]};
        end else if (VARIANT == VAR_8K) begin
            return b[2:1];
        end
        return 2'h0;
    endfunction : dev_page

    // link domain signals
    logic rst_scl_n; // reset as seen on the link clock
    logic busy_scl; // write cycle running, link-clock copy
    cs_pins_t pins_s; // synchronised straps
    eng_state_t state; // protocol state
    logic [3:0] bit_cnt; // bits of the current byte, 8 = ack slot
    logic [7:0] rx; // receive shifter
    logic [7:0] tx; // transmit shifter
    logic [7:0] rx_byte; // byte completed at this edge
    logic ack_req; // drive an acknowledge in the coming slot
    logic rd_mode; // direction bit of the last device address
    logic [1:0] page_sel; // page bits from the device address
    logic [AW-1:0] addr_cnt; // internal address counter
    logic armed; // written bytes await their timed cycle
    logic [9:0] full_addr; // word address with page bits
    logic [7:0] mem [0:DEPTH-1]; // the nonvolatile array

    // reset and straps enter the link domain through two flops
    ee_sync2 #(.WIDTH(4)) u_sync_in (
        .i_clk(i_scl),
        .i_async({i_reset_n, i_chip_select_pins}),
        .o_sync({rst_scl_n, pins_s})
    );

    // busy level back into the link domain
    ee_sync2 #(.WIDTH(1)) u_sync_busy (
        .i_clk(i_scl),
        .i_async(o_busy),
        .o_sync(busy_scl)
    );

    // timed write cycle runs on the system clock, since scl may stop after stop
    ee_write_timer #(.WRITE_CYCLES(WRITE_CYCLES)) u_timer (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .i_stop_flag(i_bus_stop),
        .i_armed(armed),
        .o_busy(o_busy)
    );

    // byte being completed by this rising edge
    assign rx_byte = {rx[6:0], i_sda};
    // address of a write: page bits from the device word, then the word address
    assign full_addr = {page_sel, rx_byte};

    // protocol sequencing, sampled on scl rising edges
    always_ff @(posedge i_scl) begin
        if (!rst_scl_n) begin
            state <= S_IDLE;
            bit_cnt <= 4'h0;
            rx <= 8'h00;
            tx <= 8'hFF;
            ack_req <= 1'b0;
            rd_mode <= 1'b0;
            page_sel <= 2'h0;
        end else if (i_bus_start) begin
            // first address bit is sampled at the edge after start
            state <= S_DEV;
            bit_cnt <= 4'h1;
            rx <= {7'h00, i_sda};
            ack_req <= 1'b0;
        end else begin
            case (state)
                S_IDLE: begin
                    // standby: wait for a start
                    ack_req <= 1'b0;
                    bit_cnt <= 4'h0;
                end
                S_DEV, S_WADDR, S_WDATA: begin
                    if (bit_cnt != `EE_BYTE_BITS) begin
                        // shift in one bit, msb first
                        rx <= rx_byte;
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == 4'h7) begin
                            if (state == S_DEV) begin
                                if (busy_scl || !dev_match(rx_byte, pins_s)) begin
                                    state <= S_IDLE;
                                end else begin
                                    ack_req <= 1'b1;
                                    rd_mode <= rx_byte[0];
                                    page_sel <= dev_page(rx_byte);
                                end
                            end else begin
                                // word address and data bytes are always acked
                                ack_req <= 1'b1;
                            end
                        end
                    end else begin
                        // ninth clock: acknowledge slot ends
                        ack_req <= 1'b0;
                        bit_cnt <= 4'h0;
                        if (state == S_DEV) begin
                            if (rd_mode) begin
                                state <= S_RDATA;
                                tx <= mem[addr_cnt];
                            end else begin
                                state <= S_WADDR;
                            end
                        end else if (state == S_WADDR) begin
                            state <= S_WDATA;
                        end
                    end
                end
                S_RDATA: begin
                    if (bit_cnt != `EE_BYTE_BITS) begin
                        // next bit goes out after the falling edge
                        tx <= {tx[6:0], 1'b1};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (!i_sda) begin
                        // master ack: fetch the following byte
                        tx <= mem[addr_cnt];
                        bit_cnt <= 4'h0;
                    end else begin
                        // master nack ends the read
                        state <= S_IDLE;
                        bit_cnt <= 4'h0;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // address counter; keeps its value between operations
    always_ff @(posedge i_scl) begin
        if (!rst_scl_n) begin
            addr_cnt <= AW'(`EE_ADDR_RESET);
        end else if (!i_bus_start) begin
            if (state == S_WADDR && bit_cnt == 4'h7) begin
                // dummy write or write loads the word address
                addr_cnt <= full_addr[AW-1:0];
            end else if (state == S_WDATA && bit_cnt == 4'h7) begin
                // only the in-page bits move, so a long burst wraps
                addr_cnt <= {addr_cnt[AW-1:PB], addr_cnt[PB-1:0] + PB'(1)};
            end else if (state == S_DEV && bit_cnt == `EE_BYTE_BITS && rd_mode && ack_req) begin
                addr_cnt <= addr_cnt + AW'(1);
            end else if (state == S_RDATA && bit_cnt == `EE_BYTE_BITS && !i_sda) begin
                // read wraps across the whole array
                addr_cnt <= addr_cnt + AW'(1);
            end
        end
    end

    // array write at each data byte; the timed cycle follows the stop
    always_ff @(posedge i_scl) begin
        if (rst_scl_n && !i_bus_start && state == S_WDATA && bit_cnt == 4'h7) begin
            mem[addr_cnt] <= rx_byte;
        end
    end

    // pending-write flag, cleared once the timer reports busy
    always_ff @(posedge i_scl) begin
        if (!rst_scl_n) begin
            armed <= 1'b0;
        end else if (busy_scl) begin
            armed <= 1'b0;
        end else if (!i_bus_start && state == S_WDATA && bit_cnt == 4'h7) begin
            armed <= 1'b1;
        end
    end

    // open-drain drive, changed only after scl falling edges
    always_ff @(negedge i_scl) begin
        if (!rst_scl_n) begin
            o_sda_oe <= 1'b0;
            o_sda_out <= 1'b0;
        end else begin
            o_sda_out <= 1'b0;
            // low for an ack or a zero data bit, released otherwise
            o_sda_oe <= ack_req || (state == S_RDATA && bit_cnt != `EE_BYTE_BITS && !tx[7]);
        end
    end
endmodule : eeprom_engine
